// ### inc/tcc_pkg.sv
// Constants, types and decode helpers for the per-channel counter control block.
// Assumes a 10 MHz peripheral clock and a single AHB-Lite slave decoded on haddr[7:0].
`default_nettype none

package tcc_pkg;

    localparam int NCH     = 5;
    localparam int PRESC_W = 10;

    // Register map, byte offsets
    localparam logic [7:0] ADDR_CTRL_BASE = 8'h00;
    localparam logic [7:0] ADDR_STRIDE    = 8'h04;
    localparam logic [7:0] ADDR_MODE      = 8'h14;
    localparam logic [7:0] ADDR_STATUS    = 8'h18;

    localparam logic [7:0]  CTRL_RESET        = 8'h00;
    localparam logic [31:0] MODE_RESET        = 32'h0000_0000;
    localparam logic [7:0]  CTRL_WMASK_FULL   = 8'hff;
    localparam logic [7:0]  CTRL_WMASK_NARROW = 8'h7f;
    localparam logic [31:0] MODE_WMASK        = 32'h0319_191f;

    // Control register fields
    localparam int CLR_MSB  = 7;
    localparam int CLR_LSB  = 5;
    localparam int EDGE_MSB = 4;
    localparam int EDGE_LSB = 3;
    localparam int EDGE_BOTH_BIT = 4;
    localparam int EDGE_FALL_BIT = 3;
    localparam int SRC_MSB  = 2;
    localparam int SRC_LSB  = 0;

    localparam logic [2:0] CLR_OFF0  = 3'h0;
    localparam logic [2:0] CLR_A     = 3'h1;
    localparam logic [2:0] CLR_B     = 3'h2;
    localparam logic [2:0] CLR_SYNC0 = 3'h3;
    localparam logic [2:0] CLR_OFF1  = 3'h4;
    localparam logic [2:0] CLR_C     = 3'h5;
    localparam logic [2:0] CLR_D     = 3'h6;
    localparam logic [2:0] CLR_SYNC1 = 3'h7;

    // Mode register fields
    localparam int MODE_SYNC_LSB    = 0;
    localparam int MODE_BUFC_LSB    = 8;
    localparam int MODE_BUFD_LSB    = 16;
    localparam int MODE_PHASE1_BIT  = 24;
    localparam int MODE_PHASE2_BIT  = 25;

    // Status register fields
    localparam int STAT_PIN_LSB   = 0;
    localparam int STAT_PRESC_LSB = 16;

    // Prescaler taps: bit k runs at clock / 2^(k+1), toggling every 2^k cycles
    localparam int TAP_DIV4    = 1;
    localparam int TAP_DIV16   = 3;
    localparam int TAP_DIV64   = 5;
    localparam int TAP_DIV256  = 7;
    localparam int TAP_DIV1024 = 9;

    typedef enum logic [3:0] {
        SRC_DIV1    = 4'h0,
        SRC_DIV4    = 4'h1,
        SRC_DIV16   = 4'h2,
        SRC_DIV64   = 4'h3,
        SRC_DIV256  = 4'h4,
        SRC_DIV1024 = 4'h5,
        SRC_PIN_A   = 4'h6,
        SRC_PIN_B   = 4'h7,
        SRC_PIN_C   = 4'h8,
        SRC_PIN_D   = 4'h9,
        SRC_OVF     = 4'ha
    } tcc_src_t;

    // Channels with general registers C and D
    function automatic logic tcc_has_cd(input int ch);
        return (ch == 0) || (ch == 3) || (ch == 4);
    endfunction

    function automatic logic [7:0] tcc_ctrl_wmask(input int ch);
        return tcc_has_cd(ch) ? CTRL_WMASK_FULL : CTRL_WMASK_NARROW;
    endfunction

    // Count source per channel and clock code
    function automatic tcc_src_t tcc_src_of(input int ch, input logic [2:0] code);
        tcc_src_t s;
        s = SRC_DIV1;
        unique case (code)
            3'h0: s = SRC_DIV1;
            3'h1: s = SRC_DIV4;
            3'h2: s = SRC_DIV16;
            3'h3: s = SRC_DIV64;
            3'h4: s = (ch >= 3) ? SRC_DIV256 : SRC_PIN_A;
            3'h5: s = (ch >= 3) ? SRC_DIV1024 : SRC_PIN_B;
            3'h6: s = (ch >= 3) ? SRC_PIN_A : ((ch == 1) ? SRC_DIV256 : SRC_PIN_C);
            3'h7: s = (ch >= 3) ? SRC_PIN_B : ((ch == 0) ? SRC_PIN_D :
                      ((ch == 1) ? SRC_OVF : SRC_DIV1024));
        endcase
        return s;
    endfunction

endpackage

`default_nettype wire

// ### logic/tcc_count_sel.sv
// One channel's count source and edge selection, purely combinational.
// Assumes pin levels already synchronised and prescaler taps from the same clock.
`default_nettype none
`timescale 1ns/10ps

module tcc_count_sel #(
    parameter int CH = 0
) (
    input  wire logic [7:0]                  ctrl,
    input  wire logic                        phase_mode,
    input  wire logic [tcc_pkg::PRESC_W-1:0] div_now,
    input  wire logic [tcc_pkg::PRESC_W-1:0] div_prev,
    input  wire logic [3:0]                  pin_now,
    input  wire logic [3:0]                  pin_prev,
    input  wire logic                        ovf_pulse,
    output logic                             count_pulse
);
    import tcc_pkg::*;

    tcc_src_t src;
    logic     now_lvl;
    logic     prev_lvl;
    logic     edge_hit;

    always_comb begin
        src      = tcc_src_of(CH, ctrl[SRC_MSB:SRC_LSB]);
        now_lvl  = 1'b0;
        prev_lvl = 1'b0;
        unique case (src)
            SRC_DIV4: begin
                now_lvl  = div_now[TAP_DIV4];
                prev_lvl = div_prev[TAP_DIV4];
            end
            SRC_DIV16: begin
                now_lvl  = div_now[TAP_DIV16];
                prev_lvl = div_prev[TAP_DIV16];
            end
            SRC_DIV64: begin
                now_lvl  = div_now[TAP_DIV64];
                prev_lvl = div_prev[TAP_DIV64];
            end
            SRC_DIV256: begin
                now_lvl  = div_now[TAP_DIV256];
                prev_lvl = div_prev[TAP_DIV256];
            end
            SRC_DIV1024: begin
                now_lvl  = div_now[TAP_DIV1024];
                prev_lvl = div_prev[TAP_DIV1024];
            end
            SRC_PIN_A: begin
                now_lvl  = pin_now[0];
                prev_lvl = pin_prev[0];
            end
            SRC_PIN_B: begin
                now_lvl  = pin_now[1];
                prev_lvl = pin_prev[1];
            end
            SRC_PIN_C: begin
                now_lvl  = pin_now[2];
                prev_lvl = pin_prev[2];
            end
            SRC_PIN_D: begin
                now_lvl  = pin_now[3];
                prev_lvl = pin_prev[3];
            end
            default: begin
                now_lvl  = 1'b0;
                prev_lvl = 1'b0;
            end
        endcase

        // Both edges of a divided clock halve its period
        if (ctrl[EDGE_BOTH_BIT]) begin
            edge_hit = now_lvl ^ prev_lvl;
        end else if (ctrl[EDGE_FALL_BIT]) begin
            edge_hit = prev_lvl & ~now_lvl;
        end else begin
            edge_hit = now_lvl & ~prev_lvl;
        end

        // Undivided clock and overflow ignore the edge field
        if (src == SRC_DIV1) begin
            count_pulse = 1'b1;
        end else if (src == SRC_OVF) begin
            count_pulse = ovf_pulse;
        end else begin
            count_pulse = edge_hit;
        end

        // Phase counting owns the counter on channels 1 and 2
        if (phase_mode) begin
            count_pulse = 1'b0;
        end
    end

endmodule

`default_nettype wire

// ### logic/tcc_top.sv
// Counter control for five timer channels: control registers over AHB-Lite,
// clear-source selection and count-enable generation per channel.
// Assumes compare/capture events and the overflow pulse arrive on hclk;
// external clock pins are asynchronous.
//
// How it works
// - Power-on reset and standby entry return every control register to zero.
// - Manual reset leaves every control register untouched.
// - Bits 7-5 choose clear source; codes 000 and 100 never clear.
// - Code 001 clears on register A event; code 010 on register B event.
// - Channels 0, 3, 4: code 101 clears on C event, 110 on D event.
// - Codes 011/111 follow clears of other synced channels when sync enabled.
// - A C or D register in buffer mode never causes a clear.
// - Channels 1 and 2: bit 7 reads zero and ignores writes.
// - Edge field: 00 rising, 01 falling, 1x both edges.
// - Both edges of a divided clock count at twice its rate.
// - Phase counting on channels 1, 2 overrides edge selection.
// - Undivided clock or overflow source counts as rising edges unless phase counting is on.
// - Bits 2-0 pick each channel's count source independently.
// - Each channel offers only its own subset of sources.
// - Channel 0: dividers 1/4/16/64, then pins A-D.
// - Channel 1: dividers 1-64, pins A-B, divide-by-256, channel 2 overflow.
// - Channel 2: dividers 1-64, pins A-C, 1024; channels 3, 4: dividers, pins A-B.
`default_nettype none
`timescale 1ns/10ps

module tcc_top (
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic      [31:0]             hrdata,
    output logic                         hreadyout,
    output logic                         hresp,
    input  wire logic                    standby_entry,
    input  wire logic                    manual_reset,
    input  wire logic [tcc_pkg::NCH-1:0] event_reg_a,
    input  wire logic [tcc_pkg::NCH-1:0] event_reg_b,
    input  wire logic [tcc_pkg::NCH-1:0] event_reg_c,
    input  wire logic [tcc_pkg::NCH-1:0] event_reg_d,
    input  wire logic                    ch2_overflow,
    input  wire logic                    ext_clock_pin_a,
    input  wire logic                    ext_clock_pin_b,
    input  wire logic                    ext_clock_pin_c,
    input  wire logic                    ext_clock_pin_d,
    output logic      [tcc_pkg::NCH-1:0] count_enable,
    output logic      [tcc_pkg::NCH-1:0] counter_clear
);
    import tcc_pkg::*;

    localparam int SEL_MODE   = NCH;
    localparam int SEL_STATUS = NCH + 1;
    localparam int SEL_NONE   = NCH + 2;

    typedef struct packed {
        logic [NCH-1:0][7:0]  ctrl;
        logic [31:0]          mode;
        logic [PRESC_W-1:0]   presc;
        logic [PRESC_W-1:0]   presc_prev;
        logic [3:0]           pin_s1;
        logic [3:0]           pin_s2;
        logic [3:0]           pin_prev;
        logic                 wr_pend;
        logic [7:0]           wr_addr;
        logic [31:0]          rdata;
        logic [NCH-1:0]       cnt_en;
        logic [NCH-1:0]       clr;
    } tcc_state_t;

    tcc_state_t     q;
    tcc_state_t     d;
    logic [NCH-1:0] cnt_pulse;
    logic [NCH-1:0] own_clr;
    logic [NCH-1:0] sync_en;
    logic [NCH-1:0] buf_c;
    logic [NCH-1:0] buf_d;
    logic           sync_src;
    logic           take;
    logic [2:0]     code;
    int             wsel;
    int             rsel;

    // Word decode of the low address byte
    function automatic int tcc_decode(input logic [7:0] addr);
        int k;
        k = SEL_NONE;
        for (int i = 0; i < NCH; i++) begin
            if (addr == ADDR_CTRL_BASE + 8'(i) * ADDR_STRIDE) begin
                k = i;
            end
        end
        if (addr == ADDR_MODE) begin
            k = SEL_MODE;
        end
        if (addr == ADDR_STATUS) begin
            k = SEL_STATUS;
        end
        return k;
    endfunction

    always_comb begin
        d        = q;
        own_clr  = '0;
        sync_src = 1'b0;
        code     = CLR_OFF0;
        sync_en  = q.mode[MODE_SYNC_LSB +: NCH];
        buf_c    = q.mode[MODE_BUFC_LSB +: NCH];
        buf_d    = q.mode[MODE_BUFD_LSB +: NCH];

        // Pin synchronisers; the second stage and its delayed copy pin_prev are looked at
        d.pin_s1   = {ext_clock_pin_d, ext_clock_pin_c, ext_clock_pin_b, ext_clock_pin_a};
        d.pin_s2   = q.pin_s1;
        d.pin_prev = q.pin_s2;

        // Prescaler restarts on standby and manual reset
        d.presc_prev = q.presc;
        if (standby_entry || manual_reset) begin
            d.presc = '0;
        end else begin
            d.presc = q.presc + PRESC_W'(1);
        end

        // Data phase of a write
        wsel = tcc_decode(q.wr_addr);
        if (q.wr_pend) begin
            if (wsel < NCH) begin
                d.ctrl[wsel] = hwdata[7:0] & tcc_ctrl_wmask(wsel);
            end else if (wsel == SEL_MODE) begin
                d.mode = hwdata & MODE_WMASK;
            end
        end

        // Standby clears; manual reset does not touch the registers
        if (standby_entry) begin
            for (int i = 0; i < NCH; i++) begin
                d.ctrl[i] = CTRL_RESET;
            end
            d.mode = MODE_RESET;
        end

        // Address phase; read data reflect a write finishing this cycle
        take      = hsel && hready && htrans[1];
        d.wr_pend = take && hwrite;
        d.wr_addr = haddr[7:0];
        rsel      = tcc_decode(haddr[7:0]);
        if (take && !hwrite) begin
            if (rsel < NCH) begin
                d.rdata = {24'h00_0000, d.ctrl[rsel]};
            end else if (rsel == SEL_MODE) begin
                d.rdata = d.mode;
            end else if (rsel == SEL_STATUS) begin
                d.rdata = '0;
                d.rdata[STAT_PIN_LSB +: 4]         = q.pin_s2;
                d.rdata[STAT_PRESC_LSB +: PRESC_W] = q.presc;
            end else begin
                d.rdata = '0;
            end
        end

        // Clears from each channel's own general registers
        for (int c = 0; c < NCH; c++) begin
            code = q.ctrl[c][CLR_MSB:CLR_LSB];
            unique case (code)
                CLR_A: own_clr[c] = event_reg_a[c];
                CLR_B: own_clr[c] = event_reg_b[c];
                CLR_C: own_clr[c] = tcc_has_cd(c) && event_reg_c[c] && !buf_c[c];
                CLR_D: own_clr[c] = tcc_has_cd(c) && event_reg_d[c] && !buf_d[c];
                default: own_clr[c] = 1'b0;
            endcase
        end
        sync_src = |(own_clr & sync_en);

        // Synchronous clear follows any synced channel's own clear
        for (int c = 0; c < NCH; c++) begin
            code     = q.ctrl[c][CLR_MSB:CLR_LSB];
            d.clr[c] = own_clr[c];
            if ((code == CLR_SYNC0) || (code == CLR_SYNC1)) begin
                d.clr[c] = sync_en[c] && sync_src;
            end
        end

        d.cnt_en = cnt_pulse;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    genvar g;
    generate
        for (g = 0; g < NCH; g++) begin : g_ch
            tcc_count_sel #(
                .CH (g)
            ) u_sel (
                .ctrl        (q.ctrl[g]),
                .phase_mode  ((g == 1) ? q.mode[MODE_PHASE1_BIT] :
                              ((g == 2) ? q.mode[MODE_PHASE2_BIT] : 1'b0)),
                .div_now     (q.presc),
                .div_prev    (q.presc_prev),
                .pin_now     (q.pin_s2),
                .pin_prev    (q.pin_prev),
                .ovf_pulse   (ch2_overflow),
                .count_pulse (cnt_pulse[g])
            );
        end
    endgenerate

    assign hrdata        = q.rdata;
    assign hreadyout     = 1'b1;
    assign hresp         = 1'b0;
    assign count_enable  = q.cnt_en;
    assign counter_clear = q.clr;

endmodule

`default_nettype wire

// ### dv/tcc_assertions.sv
// Checker for tcc_top: shadows control and mode registers from bus traffic.
// Assumes zero-wait single-word AHB-Lite writes and hclk-domain events.
`timescale 1ns/10ps
`default_nettype none
module tcc_checker (
    input wire logic                    hclk,
    input wire logic                    hresetn,
    input wire logic                    hsel,
    input wire logic [31:0]             haddr,
    input wire logic [1:0]              htrans,
    input wire logic                    hwrite,
    input wire logic [31:0]             hwdata,
    input wire logic                    hready,
    input wire logic [31:0]             hrdata,
    input wire logic                    standby_entry,
    input wire logic                    manual_reset,
    input wire logic [tcc_pkg::NCH-1:0] event_reg_a,
    input wire logic [tcc_pkg::NCH-1:0] event_reg_b,
    input wire logic [tcc_pkg::NCH-1:0] event_reg_c,
    input wire logic [tcc_pkg::NCH-1:0] count_enable,
    input wire logic [tcc_pkg::NCH-1:0] counter_clear
);
    import tcc_pkg::*;
    logic                  wr_q;
    logic                  rd_q;
    logic [7:0]            a_q;
    logic [NCH-1:0][7:0]   m_q;
    logic [31:0]           md_q;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            a_q  <= 8'h00;
            m_q  <= '0;
            md_q <= 32'h0;
        end else begin
            wr_q <= hsel && hready && htrans[1] && hwrite;
            rd_q <= hsel && hready && htrans[1] && !hwrite;
            a_q  <= haddr[7:0];
            if (standby_entry) begin
                m_q  <= '0;
                md_q <= 32'h0;
            end else if (wr_q && a_q < ADDR_MODE) begin
                m_q[a_q[4:2]] <= hwdata[7:0] & ((a_q[4:2] == 3'h1 || a_q[4:2] == 3'h2) ? 8'h7f : 8'hff);
            end else if (wr_q && a_q == ADDR_MODE) begin
                md_q <= hwdata & MODE_WMASK;
            end
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    property p_standby; standby_entry |=> ##1 (counter_clear == 5'h00); endproperty
    a_standby: assert property (p_standby) else $error("clear after standby");
    property p_noclr; (m_q[0][7:5] == CLR_OFF0 || m_q[0][7:5] == CLR_OFF1) |=> !counter_clear[0]; endproperty
    a_noclr: assert property (p_noclr) else $error("clear while disabled");
    property p_clr_a; m_q[0][7:5] == CLR_A && event_reg_a[0] |=> counter_clear[0]; endproperty
    a_clr_a: assert property (p_clr_a) else $error("no clear on A");
    property p_clr_b; m_q[1][7:5] == CLR_B && event_reg_b[1] |=> counter_clear[1]; endproperty
    a_clr_b: assert property (p_clr_b) else $error("no clear on B");
    property p_clr_c; m_q[3][7:5] == CLR_C && !md_q[MODE_BUFC_LSB+3] && event_reg_c[3] |=> counter_clear[3]; endproperty
    a_clr_c: assert property (p_clr_c) else $error("no clear on C");
    property p_buf; m_q[3][7:5] == CLR_C && md_q[MODE_BUFC_LSB+3] |=> !counter_clear[3]; endproperty
    a_buf: assert property (p_buf) else $error("clear from buffer register");
    property p_sync;
        md_q[0] && md_q[3] && m_q[0][7:5] == CLR_A && m_q[3][7:5] == CLR_SYNC0 && event_reg_a[0] |=> counter_clear[3];
    endproperty
    a_sync: assert property (p_sync) else $error("no sync clear");
    property p_rsv; rd_q && (a_q == 8'h04 || a_q == 8'h08) |-> hrdata[7] == 1'b0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit set");
    property p_div1; m_q[0][2:0] == 3'h0 && $stable(m_q[0]) && !standby_entry && !manual_reset |=> count_enable[0]; endproperty
    a_div1: assert property (p_div1) else $error("undivided count missing");
    property p_both;
        m_q[3] == 8'h11 && $stable(m_q[3]) && $past(m_q[3], 2) == 8'h11 && !standby_entry && !manual_reset
            |=> count_enable[3] != $past(count_enable[3]);
    endproperty
    a_both: assert property (p_both) else $error("both-edge rate wrong");
endmodule
bind tcc_top tcc_checker u_tcc_checker (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .standby_entry(standby_entry), .manual_reset(manual_reset), .event_reg_a(event_reg_a),
    .event_reg_b(event_reg_b), .event_reg_c(event_reg_c), .count_enable(count_enable),
    .counter_clear(counter_clear));
`default_nettype wire

// ### dv/timer_count_clock_clear_select_test.sv
// Testbench for tcc_top: register access, clear selection and count rates.
// Assumes a 10 MHz clock and a zero-wait AHB-Lite slave.
`timescale 1ns/10ps
`default_nettype none
module timer_count_clock_clear_select_test;
    import tcc_pkg::*;
    logic                 hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic                 standby_entry, manual_reset, ch2_overflow;
    logic [31:0]          haddr, hwdata, hrdata;
    logic [1:0]           htrans;
    logic [2:0]           hsize;
    logic [3:0][NCH-1:0]  ev;
    logic [NCH-1:0]       count_enable, counter_clear;
    logic [3:0]           pins;
    int                   fail_count = 0;
    int                   cmp_count = 0;
    int                   cyc = 0;

    assign hready = hreadyout;
    tcc_top u_tcc_top (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .standby_entry(standby_entry), .manual_reset(manual_reset),
        .event_reg_a(ev[0]), .event_reg_b(ev[1]), .event_reg_c(ev[2]), .event_reg_d(ev[3]),
        .ch2_overflow(ch2_overflow), .ext_clock_pin_a(pins[0]), .ext_clock_pin_b(pins[1]),
        .ext_clock_pin_c(pins[2]), .ext_clock_pin_d(pins[3]), .count_enable(count_enable),
        .counter_clear(counter_clear));

    initial begin
        hclk = 1'b0;
        forever #50 hclk = ~hclk;
    end

    task automatic finish_test();
        if (fail_count == 0 && cmp_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Overflow pulse every 8 cycles; run ceiling
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        ch2_overflow <= (cyc[2:0] == 3'h7);
        if (cyc == 20000) begin
            fail_count++;
            finish_test();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            fail_count++;
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        r = hrdata;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, e);
        chk({30'h0, hreadyout, hresp}, 32'h0000_0002);
    endtask

    task automatic rd_all(input logic [7:0] v);
        for (int ch = 0; ch < NCH; ch++) rd(8'(4 * ch), {24'h0, v & ((ch == 1 || ch == 2) ? 8'h7f : 8'hff)});
    endtask

    task automatic rst_pulse(input logic sb);
        @(posedge hclk);
        if (sb)
            standby_entry <= 1'b1;
        else
            manual_reset <= 1'b1;
        @(posedge hclk);
        standby_entry <= 1'b0;
        manual_reset <= 1'b0;
    endtask

    // One event cycle on source src of channel ch, clear pulse checked next cycle
    task automatic fire(input int ch, input int src, input logic [NCH-1:0] exp);
        @(posedge hclk);
        ev <= {15'h0, 5'(1) << ch} << (NCH * src);
        @(posedge hclk);
        ev <= '0;
        #1 chk({27'h0, counter_clear}, {27'h0, exp});
    endtask

    task automatic cnt(input int ch, input logic [7:0] v, input int pin, input int n, input int exp);
        int c;
        c = 0;
        wr(8'(4 * ch), {24'h0, v});
        repeat (4) @(posedge hclk);
        for (int i = 0; i < n; i++) begin
            @(posedge hclk);
            if (pin < 4 && i < n - 8 && i % 4 == 0) pins[pin] <= ~pins[pin];
            #1 if (count_enable[ch] !== 1'b0) c++;
        end
        chk(32'(c), 32'(exp));
    endtask

    task automatic t_regs();
        rd_all(8'h00);
        for (int ch = 0; ch < NCH; ch++) wr(8'(4 * ch), 32'hff);
        rd_all(8'hff);
        wr(8'h40, 32'hff);
        rd(8'h40, 32'h0);
        rst_pulse(1'b0);
        rd_all(8'hff);
        rst_pulse(1'b1);
        rd_all(8'h00);
        for (int ch = 0; ch < NCH; ch++) wr(8'(4 * ch), 32'hff);
        @(posedge hclk);
        hresetn <= 1'b0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        rd_all(8'h00);
    endtask

    task automatic t_status();
        logic [31:0] r;
        pins <= 4'h5;
        repeat (4) @(posedge hclk);
        bus(1'b0, ADDR_STATUS, 32'h0, r);
        chk(r & 32'h0000_000f, 32'h0000_0005);
        pins <= 4'h0;
    endtask

    task automatic t_clear();
        for (int code = 0; code < 8; code++) begin
            wr(8'h00, 32'(code) << 5);
            for (int s = 0; s < 4; s++) fire(0, s, 5'(code == (s < 2 ? s + 1 : s + 3)));
        end
        wr(8'h04, 32'hc0);
        fire(1, 1, 5'h02);
        wr(8'h00, 32'h20);
        wr(8'h0c, 32'ha0);
        fire(3, 2, 5'h08);
        wr(ADDR_MODE, 32'h0000_0809);
        fire(3, 2, 5'h00);
        wr(8'h0c, 32'h60);
        wr(8'h10, 32'he0);
        fire(0, 0, 5'h09);
        wr(ADDR_MODE, 32'h0008_0019);
        wr(8'h0c, 32'hc0);
        fire(3, 3, 5'h00);
        fire(0, 0, 5'h11);
        rst_pulse(1'b1);
    endtask

    task automatic t_count();
        cnt(0, 8'h01, 4, 64, 16);
        cnt(0, 8'h09, 4, 64, 16);
        cnt(3, 8'h11, 4, 64, 32);
        cnt(0, 8'h12, 4, 64, 8);
        cnt(0, 8'h18, 4, 64, 64);
        cnt(0, 8'h03, 4, 64, 1);
        cnt(1, 8'h17, 4, 64, 8);
        cnt(1, 8'h06, 4, 256, 1);
        cnt(3, 8'h04, 4, 256, 1);
        cnt(2, 8'h07, 4, 1024, 1);
        cnt(4, 8'h05, 4, 1024, 1);
        cnt(0, 8'h04, 0, 64, 7);
        cnt(0, 8'h0d, 1, 64, 7);
        cnt(0, 8'h16, 2, 64, 14);
        cnt(0, 8'h07, 3, 64, 7);
        cnt(1, 8'h05, 1, 64, 7);
        cnt(2, 8'h06, 2, 64, 7);
        cnt(3, 8'h06, 0, 64, 7);
        cnt(4, 8'h07, 1, 64, 7);
        wr(ADDR_MODE, 32'h0100_0000);
        cnt(1, 8'h10, 4, 64, 0);
        wr(ADDR_MODE, 32'hffff_ffff);
        rd(ADDR_MODE, 32'h0319_191f);
        cnt(2, 8'h00, 4, 64, 0);
    endtask

    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        standby_entry = 1'b0;
        manual_reset = 1'b0;
        ev = '0;
        pins = 4'h0;
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs();
        t_clear();
        t_count();
        t_status();
        finish_test();
    end
endmodule
`default_nettype wire
